// ===== hw/qdmc_main_control.v
// main control register with serial frame write port and derived controls
`timescale 1ns/10ps
`include "qdmc_map.vh"
module qdmc_main_control #(
  parameter [31:0] WD_CYC0 = `QDMC_WD_MS0 * `QDMC_CLK_KHZ,
  parameter [31:0] WD_CYC1 = `QDMC_WD_MS1 * `QDMC_CLK_KHZ,
  parameter [31:0] WD_CYC2 = `QDMC_WD_MS2 * `QDMC_CLK_KHZ,
  parameter [31:0] WD_CYC3 = `QDMC_WD_MS3 * `QDMC_CLK_KHZ
) (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // serial frame pins
  input wire SCLK,
  input wire SYNC_N,
  input wire SDIN,
  // idle level pin
  input wire IDLE_LEVEL_PIN,
  // per-channel output state from channel logic
  input wire [3:0] CHAN_OUT_EN,
  // control outputs
  output reg [15:0] MAIN_CONTROL,
  output reg [3:0] IDLE_LEVEL,
  output reg STATUS_READBACK_EN,
  output reg SHORT_LIMIT_8MA,
  output reg [3:0] OUTPUT_ENABLE_ALL,
  output reg [3:0] BOOST_POWER_ALL,
  output reg WATCHDOG_EXPIRED,
  output reg FRAME_DONE
);
  reg [1:0] sclk_sync;
  reg [1:0] sync_sync;
  reg [1:0] sdin_sync;
  reg sclk_d;
  reg sync_d;
  reg [23:0] shift;
  reg [4:0] nbits;
  reg frame_ok;
  // one-hot receiver states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_OVER = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] idle_sync;
  wire [3:0] next_idle_level;
  // edges found after the sync flops, never on the raw pin
  wire sclk_fall = sclk_d & ~sclk_sync[1];
  wire frame_end = ~sync_d & sync_sync[1];
  wire wd_expired;
  // reads and other registers decode to no write
  wire hit_main = shift[`QDMC_RW_BIT] == 1'b0 &&
    shift[`QDMC_GROUP_HI:`QDMC_GROUP_LO] == `QDMC_GROUP_CTRL &&
    shift[`QDMC_SEL_HI:`QDMC_SEL_LO] == `QDMC_SEL_MAIN;

  // two flops before any logic reads the pins
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sclk_sync <= 2'h0;
      // select idles high, so no false frame end after reset
      sync_sync <= 2'h3;
      sdin_sync <= 2'h0;
      sclk_d <= 1'b0;
      sync_d <= 1'b1;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], SCLK};
      sync_sync <= {sync_sync[0], SYNC_N};
      sdin_sync <= {sdin_sync[0], SDIN};
      sclk_d <= sclk_sync[1];
      sync_d <= sync_sync[1];
    end
  end

  // a 25th falling edge marks the frame over-length until select rises
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (!sync_d)
          next_state = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (sync_d)
          next_state = ST_IDLE;
        else if (sclk_fall && nbits == 5'h18)
          next_state = ST_OVER;
      end
      ST_OVER:
      begin
        if (sync_d)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // data sampled on falling serial clock, msb first
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= ST_IDLE;
      shift <= 24'h0;
      nbits <= 5'h0;
    end
    else
    begin
      state <= next_state;
      if (sync_d)
        nbits <= 5'h0;
      else if (sclk_fall)
      begin
        shift <= {shift[22:0], sdin_sync[1]};
        if (nbits != 5'h18)
          nbits <= nbits + 5'h1;
      end
    end
  end

  // frames of other lengths are dropped whole
  always @*
  begin
    frame_ok = frame_end && state == ST_SHIFT && nbits == 5'h18;
  end

  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      MAIN_CONTROL <= `QDMC_MAIN_RESET;
      FRAME_DONE <= 1'b0;
    end
    else
    begin
      FRAME_DONE <= frame_ok;
      // unused bits always read back as 0
      if (frame_ok && hit_main)
        MAIN_CONTROL <= shift[15:0] & `QDMC_MAIN_MASK;
    end
  end

  // expiry only reported, nothing acts on it here
  qdmc_watchdog #(
    .CYC0(WD_CYC0),
    .CYC1(WD_CYC1),
    .CYC2(WD_CYC2),
    .CYC3(WD_CYC3)
  ) u_wd (
    .clk(MCLK),
    .arst_n(ARST_N),
    .enable(MAIN_CONTROL[`QDMC_WDEN_BIT]),
    .sel({MAIN_CONTROL[`QDMC_WDHI_BIT], MAIN_CONTROL[`QDMC_WDLO_BIT]}),
    .access(frame_ok),
    .expired(wd_expired)
  );

  // derived controls, registered so outputs come from flops
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      IDLE_LEVEL <= 4'h0;
      STATUS_READBACK_EN <= 1'b0;
      SHORT_LIMIT_8MA <= 1'b0;
      OUTPUT_ENABLE_ALL <= 4'h0;
      BOOST_POWER_ALL <= 4'h0;
      WATCHDOG_EXPIRED <= 1'b0;
    end
    else
    begin
      STATUS_READBACK_EN <= MAIN_CONTROL[`QDMC_STAT_BIT];
      SHORT_LIMIT_8MA <= MAIN_CONTROL[`QDMC_SCL_BIT];
      OUTPUT_ENABLE_ALL <= {4{MAIN_CONTROL[`QDMC_OUTALL_BIT]}};
      // powering down with outputs still on is the host's fault to avoid
      BOOST_POWER_ALL <= {4{MAIN_CONTROL[`QDMC_BOOSTALL_BIT]}};
      WATCHDOG_EXPIRED <= wd_expired;
      IDLE_LEVEL <= next_idle_level;
    end
  end

  // idle level pin gets its own two flops
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      idle_sync <= 2'h0;
    else
      idle_sync <= {idle_sync[0], IDLE_LEVEL_PIN};
  end

  // enabled channels show 0 here; the level only matters while idle
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_chan
      assign next_idle_level[g] = (CHAN_OUT_EN[g] | MAIN_CONTROL[`QDMC_OUTALL_BIT]) ? 1'b0 :
        (idle_sync[1] ^ MAIN_CONTROL[`QDMC_POL_BIT]);
    end
  endgenerate
endmodule // qdmc_main_control

// ===== hw/qdmc_map.vh
// field positions, codes and timing constants of the main control register block
`ifndef QDMC_MAP_VH
`define QDMC_MAP_VH
`define QDMC_FRAME_BITS 24
`define QDMC_RW_BIT 23
`define QDMC_GROUP_HI 20
`define QDMC_GROUP_LO 18
`define QDMC_GROUP_CTRL 3'h7
`define QDMC_SEL_HI 15
`define QDMC_SEL_LO 13
`define QDMC_SEL_MAIN 3'h1
`define QDMC_MAIN_RESET 16'h0000
`define QDMC_MAIN_MASK 16'h1f70
`define QDMC_POL_BIT 12
`define QDMC_STAT_BIT 11
`define QDMC_WDEN_BIT 10
`define QDMC_WDHI_BIT 9
`define QDMC_WDLO_BIT 8
`define QDMC_SCL_BIT 6
`define QDMC_OUTALL_BIT 5
`define QDMC_BOOSTALL_BIT 4
`define QDMC_CLK_KHZ 40000
`define QDMC_WD_MS0 5
`define QDMC_WD_MS1 10
`define QDMC_WD_MS2 100
`define QDMC_WD_MS3 200
`endif

// ===== hw/qdmc_watchdog.v
// watchdog timer counting from the last valid interface access
`timescale 1ns/10ps
`include "qdmc_map.vh"
module qdmc_watchdog #(
  parameter [31:0] CYC0 = `QDMC_WD_MS0 * `QDMC_CLK_KHZ,
  parameter [31:0] CYC1 = `QDMC_WD_MS1 * `QDMC_CLK_KHZ,
  parameter [31:0] CYC2 = `QDMC_WD_MS2 * `QDMC_CLK_KHZ,
  parameter [31:0] CYC3 = `QDMC_WD_MS3 * `QDMC_CLK_KHZ
) (
  input wire clk,
  input wire arst_n,
  input wire enable,
  input wire [1:0] sel,
  input wire access,
  output reg expired
);
  reg [31:0] count;
  reg [31:0] limit;
  always @*
  begin
    case (sel)
      2'h0: limit = CYC0;
      2'h1: limit = CYC1;
      2'h2: limit = CYC2;
      default: limit = CYC3;
    endcase
  end
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= 32'h0;
      expired <= 1'b0;
    end
    else if (!enable || access)
    begin
      count <= 32'h0;
      expired <= 1'b0;
    end
    else if (count + 32'h1 >= limit)
      expired <= 1'b1;
    else
      count <= count + 32'h1;
  end
endmodule // qdmc_watchdog

// ===== tb/qdmc_host.sv
// host model sending serial frames
`timescale 1ns/10ps
module qdmc_host (
  // pins
  input wire MCLK,
  output logic SCLK,
  output logic SYNC_N,
  output logic SDIN
);
  initial
  begin
    SCLK = 1'b0;
    SYNC_N = 1'b1;
    SDIN = 1'b0;
  end
  // clock stands low outside frames
  task send(input [24:0] f, input int n);
    @(posedge MCLK) SYNC_N <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      SDIN <= f[n - 1 - i];
      repeat (3) @(posedge MCLK);
      SCLK <= 1'b1;
      repeat (3) @(posedge MCLK);
      SCLK <= 1'b0;
      repeat (3) @(posedge MCLK);
    end
    SYNC_N <= 1'b1;
    SDIN <= ~SDIN;
    repeat (5) @(posedge MCLK);
  endtask
endmodule // qdmc_host

// ===== tb/qdmc_main_control_chk.sv
// assertions on the main control ports
`timescale 1ns/10ps
module qdmc_chk #(parameter [31:0] WD_CYC0 = 20, WD_CYC1 = 40, WD_CYC2 = 60, WD_CYC3 = 80) (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // watched
  input wire IDLE_LEVEL_PIN,
  input wire [3:0] CHAN_OUT_EN,
  input wire [15:0] MAIN_CONTROL,
  input wire [3:0] IDLE_LEVEL,
  input wire STATUS_READBACK_EN,
  input wire SHORT_LIMIT_8MA,
  input wire [3:0] OUTPUT_ENABLE_ALL,
  input wire [3:0] BOOST_POWER_ALL,
  input wire WATCHDOG_EXPIRED,
  input wire FRAME_DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // six calm cycles cover pin sync and pipeline
  sequence s_calm;
    (!MAIN_CONTROL[5] && CHAN_OUT_EN == 4'h0 && $stable(MAIN_CONTROL) && $stable(IDLE_LEVEL_PIN)) [*6];
  endsequence
  a_reserved_zero: assert property ((MAIN_CONTROL & 16'he08f) == 16'h0) else $error("reserved bit");
  a_idle_pol: assert property (s_calm |-> IDLE_LEVEL == {4{IDLE_LEVEL_PIN ^ MAIN_CONTROL[12]}})
    else $error("idle level");
  a_stat_follow: assert property (STATUS_READBACK_EN == $past(MAIN_CONTROL[11])) else $error("readback");
  a_limit_follow: assert property (SHORT_LIMIT_8MA == $past(MAIN_CONTROL[6])) else $error("limit");
  a_out_all: assert property (OUTPUT_ENABLE_ALL == {4{$past(MAIN_CONTROL[5])}}) else $error("out all");
  a_boost_all: assert property (BOOST_POWER_ALL == {4{$past(MAIN_CONTROL[4])}}) else $error("boost");
  a_write_done: assert property ($changed(MAIN_CONTROL) |-> FRAME_DONE) else $error("stray write");
  a_wd_off: assert property (!MAIN_CONTROL[10] [*3] |-> !WATCHDOG_EXPIRED) else $error("wd off");
  a_wd_restart: assert property (FRAME_DONE |-> ##2 !WATCHDOG_EXPIRED [*8]) else $error("wd restart");
endmodule // qdmc_chk
bind qdmc_main_control qdmc_chk #(.WD_CYC0(WD_CYC0), .WD_CYC1(WD_CYC1), .WD_CYC2(WD_CYC2), .WD_CYC3(WD_CYC3))
  chk (.MCLK(MCLK), .ARST_N(ARST_N), .IDLE_LEVEL_PIN(IDLE_LEVEL_PIN), .CHAN_OUT_EN(CHAN_OUT_EN),
  .MAIN_CONTROL(MAIN_CONTROL), .IDLE_LEVEL(IDLE_LEVEL), .STATUS_READBACK_EN(STATUS_READBACK_EN),
  .SHORT_LIMIT_8MA(SHORT_LIMIT_8MA), .OUTPUT_ENABLE_ALL(OUTPUT_ENABLE_ALL), .BOOST_POWER_ALL(BOOST_POWER_ALL),
  .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .FRAME_DONE(FRAME_DONE));

// ===== tb/qdmc_testbench.sv
// self-checking bench for the main control register
`timescale 1ns/10ps
module testbench;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic pin = 1'b0;
  logic [3:0] ch = 4'h0;
  wire sclk, sync_n, sdin, wdx, done, sre, scl;
  wire [15:0] mc;
  wire [3:0] il, oea, bpa;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int n_done = 0;
  logic [24:0] f[5] = '{25'h183fff, 25'h1c1fff, 25'h9c3fff, 25'h1c3fff, 25'h1c3fff};
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    if (done === 1'b1)
      n_done++;
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      results();
    end
  end
  qdmc_host host (.MCLK(MCLK), .SCLK(sclk), .SYNC_N(sync_n), .SDIN(sdin));
  qdmc_main_control #(.WD_CYC0(20), .WD_CYC1(40), .WD_CYC2(60), .WD_CYC3(80)) uut (.MCLK(MCLK),
    .ARST_N(ARST_N), .SCLK(sclk), .SYNC_N(sync_n), .SDIN(sdin), .IDLE_LEVEL_PIN(pin), .CHAN_OUT_EN(ch),
    .MAIN_CONTROL(mc), .IDLE_LEVEL(il), .STATUS_READBACK_EN(sre), .SHORT_LIMIT_8MA(scl),
    .OUTPUT_ENABLE_ALL(oea), .BOOST_POWER_ALL(bpa), .WATCHDOG_EXPIRED(wdx), .FRAME_DONE(done));
  task chk(input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input [12:0] d);
    host.send({1'b0, 8'h1c, 3'h1, d}, 24);
    repeat (4) @(posedge MCLK);
  endtask
  task t_fields;
    chk({mc, sre, scl, oea, bpa, wdx, il}, 32'h0);
    wr(13'h1fff);
    chk(mc, 32'h1f70);
    chk({sre, scl, oea, bpa}, 32'h3ff);
    // outputs go off before boost power-down
    wr(13'h0010);
    chk({sre, scl, oea, bpa}, 32'h00f);
    wr(13'h0);
    chk(mc, 32'h0);
    // last entry is a valid write behind one extra leading bit
    for (int k = 0; k < 5; k++)
    begin
      host.send(f[k], (k == 3) ? 23 : (k == 4) ? 25 : 24);
      repeat (4) @(posedge MCLK);
      chk(mc, 32'h0);
    end
    chk(n_done, 32'h6);
    $display("t_fields done");
  endtask
  task t_idle;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge MCLK) pin <= k[0];
      wr({k[1], 12'h0});
      repeat (8) @(posedge MCLK);
      chk(il, {28'h0, {4{k[0] ^ k[1]}}});
    end
    wr(13'h0);
    @(posedge MCLK) ch <= 4'h5;
    repeat (8) @(posedge MCLK);
    chk(il, 32'ha);
    @(posedge MCLK) ch <= 4'h0;
    wr(13'h0020);
    repeat (2) @(posedge MCLK);
    chk(il, 32'h0);
    wr(13'h0);
    $display("t_idle done");
  endtask
  task t_wd;
    for (int k = 0; k < 4; k++)
    begin
      wr({2'h0, 1'b1, k[1:0], 8'h0});
      n = 0;
      while (wdx !== 1'b1 && n < 200)
      begin
        @(posedge MCLK);
        n++;
      end
      chk(n >= 20 * k + 12 && n <= 20 * k + 22, 32'h1);
    end
    wr(13'h0);
    chk(wdx, 32'h0);
    // well past the longest timeout with no frame
    repeat (100) @(posedge MCLK);
    chk(wdx, 32'h0);
    $display("t_wd done");
  endtask
  task t_reset;
    wr(13'h1fff);
    @(posedge MCLK) ARST_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk({mc, sre, scl, oea, bpa, wdx, done}, 32'h0);
    ARST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk({mc, sre, scl, oea, bpa, wdx}, 32'h0);
    $display("t_reset done");
  endtask
  task results;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge MCLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_fields();
    t_idle();
    t_reset();
    t_wd();
    results();
  end
endmodule // testbench
